// >>> logic/fos_pkg.sv
// shared constants and types of the flash operation state sequencer
package fos_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] REG_REGULATOR_MODE   = 8'h00;
    localparam logic [7:0] REG_FLASH_WPROT      = 8'h04;
    localparam logic [7:0] REG_FLASH_MODE       = 8'h08;
    localparam logic [7:0] REG_CONTROL          = 8'h0C;
    localparam logic [7:0] REG_STATUS           = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS       = 8'h14;
    localparam logic [7:0] REG_IRQ_CLEAR        = 8'h18;
    localparam logic [7:0] REG_IRQ_ENABLE       = 8'h1C;
    localparam logic [7:0] REG_VDD_RESULT       = 8'h20;
    // ==========================================
    // field positions and reset values
    localparam int         LOW_POWER_BIT        = 6;
    localparam int         WRITE_ENABLE_BIT     = 0;
    localparam int         CTRL_MEASURE_BIT     = 0;
    localparam int         CTRL_CPU_SUB_BIT     = 1;
    localparam logic [7:0] REGULATOR_RESET      = 8'h00;
    localparam logic [7:0] WPROT_RESET          = 8'h01;
    localparam logic [2:0] IRQ_RESET            = 3'h0;
    localparam int         IRQ_STEP             = 0;
    localparam int         IRQ_HS_REFUSED       = 1;
    localparam int         IRQ_WRITE_REFUSED    = 2;
    // ==========================================
    // supply window for high-speed entry, millivolts
    localparam logic [11:0] HS_VDD_MIN_MV       = 12'h960;
    localparam logic [11:0] HS_VDD_MAX_MV       = 12'hE10;
    // ==========================================
    // axi responses
    localparam logic [1:0] RESP_OKAY            = 2'h0;
    localparam logic [1:0] RESP_SLVERR          = 2'h2;
    // ==========================================
    // flash operating modes and frequencies
    typedef enum logic [1:0] {
        FM_LOW_VOLTAGE = 2'h0,
        FM_LOW_SPEED   = 2'h1,
        FM_HIGH_SPEED  = 2'h2,
        FM_LOW_POWER   = 2'h3
    } fos_mode_e;
    localparam logic [4:0] FREQ_1MHZ            = 5'h01;
    localparam logic [4:0] FREQ_4MHZ            = 5'h04;
    localparam logic [4:0] FREQ_8MHZ            = 5'h08;
    localparam logic [4:0] FREQ_16MHZ           = 5'h10;
    typedef enum logic [3:0] {
        POS_LV_HOCO4, POS_LV_MOCO4, POS_LS_LC_MOCO4, POS_LS_N8, POS_HS16,
        POS_HS_ERROR, POS_LS_AFTER_HS, POS_LP1, POS_LS_AFTER_LP
    } fos_pos_e;
    typedef struct packed {
        fos_mode_e  mode;
        logic       low_power_reg;
        logic       middle_osc;
        logic [4:0] freq_mhz;
    } fos_cfg_s;
endpackage : fos_pkg

// >>> logic/fos_btn_if.sv
// carrier between the button front end and the sequencer
`timescale 1ns/1ps
interface fos_btn_if;
    logic level;
    logic press;
    modport src (output level, output press);
    modport dst (input level, input press);
endinterface : fos_btn_if

// >>> logic/fos_btn_sync.sv
// button pin synchroniser and press detector
`timescale 1ns/1ps
module fos_btn_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clk_en,
    // pin
    input  wire logic button_external_interrupt,
    // to sequencer
    fos_btn_if.src    btn
);
    logic [2:0] sync_q;
    logic       level_q;
    logic       press_q;

    // ==========================================
    // three stages, change taken when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_q <= 3'h0;
        end else if (clk_en) begin
            sync_q <= {sync_q[1:0], button_external_interrupt};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
            press_q <= 1'b0;
        end else if (clk_en) begin
            press_q <= 1'b0;
            if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
                press_q <= sync_q[2] & ~level_q;
            end
        end
    end

    assign btn.level = level_q;
    assign btn.press = press_q;
endmodule : fos_btn_sync

// >>> logic/fos_sequencer.sv
// flash operation state sequencer with axi4-lite register slave
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module fos_sequencer #(
    parameter int GPIO_W    = 16,
    parameter int TOOL_PIN  = 0
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // axi4-lite write address and data
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [7:0]        s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // button pin
    input  wire logic              button_external_interrupt,
    // supply measurement
    output logic                   vdd_meas_req,
    input  wire logic              vdd_meas_valid,
    input  wire logic [11:0]       vdd_meas_mv,
    // operating state outputs
    output logic [1:0]             flash_operating_mode_select,
    output logic                   regulator_low_power_select,
    output logic                   main_clock_middle_osc,
    output logic [4:0]             osc_freq_mhz,
    output logic                   cpu_clock_source_select,
    output logic                   halt_active,
    output logic                   periph_stop,
    // general pins
    output logic [GPIO_W-1:0]      gpio_out,
    output logic [GPIO_W-1:0]      gpio_oe,
    // interrupt
    output logic                   irq
);
    // refuse pin settings the output loop cannot serve
    if (GPIO_W < 1 || GPIO_W > 32 || TOOL_PIN < 0 || TOOL_PIN >= GPIO_W) begin : g_bad_pins
        $error("fos_sequencer: bad pin parameters");
    end

    typedef enum logic [1:0] {PH_IDLE, PH_MEAS, PH_UNLOCK, PH_WRITE} fos_phase_e;

    // ==========================================
    // state order and per-state configuration
    function automatic fos_pkg::fos_pos_e seq_next(input fos_pkg::fos_pos_e p, input logic vdd_ok);
        unique case (p)
            fos_pkg::POS_LV_HOCO4:    seq_next = fos_pkg::POS_LV_MOCO4;
            fos_pkg::POS_LV_MOCO4:    seq_next = fos_pkg::POS_LS_LC_MOCO4;
            fos_pkg::POS_LS_LC_MOCO4: seq_next = fos_pkg::POS_LS_N8;
            fos_pkg::POS_LS_N8:       seq_next = vdd_ok ? fos_pkg::POS_HS16 : fos_pkg::POS_HS_ERROR;
            fos_pkg::POS_HS16:        seq_next = fos_pkg::POS_LS_AFTER_HS;
            fos_pkg::POS_HS_ERROR:    seq_next = fos_pkg::POS_LS_AFTER_HS;
            fos_pkg::POS_LS_AFTER_HS: seq_next = fos_pkg::POS_LP1;
            fos_pkg::POS_LP1:         seq_next = fos_pkg::POS_LS_AFTER_LP;
            fos_pkg::POS_LS_AFTER_LP: seq_next = fos_pkg::POS_LV_HOCO4;
            default:                  seq_next = fos_pkg::POS_LV_HOCO4;
        endcase
    endfunction : seq_next

    function automatic fos_pkg::fos_cfg_s cfg_of(input fos_pkg::fos_pos_e p);
        unique case (p)
            fos_pkg::POS_LV_HOCO4:    cfg_of = '{fos_pkg::FM_LOW_VOLTAGE, 1'b0, 1'b0, fos_pkg::FREQ_4MHZ};
            fos_pkg::POS_LV_MOCO4:    cfg_of = '{fos_pkg::FM_LOW_VOLTAGE, 1'b0, 1'b1, fos_pkg::FREQ_4MHZ};
            fos_pkg::POS_LS_LC_MOCO4: cfg_of = '{fos_pkg::FM_LOW_SPEED,   1'b1, 1'b1, fos_pkg::FREQ_4MHZ};
            fos_pkg::POS_HS16:        cfg_of = '{fos_pkg::FM_HIGH_SPEED,  1'b0, 1'b0, fos_pkg::FREQ_16MHZ};
            fos_pkg::POS_LP1:         cfg_of = '{fos_pkg::FM_LOW_POWER,   1'b0, 1'b1, fos_pkg::FREQ_1MHZ};
            default:                  cfg_of = '{fos_pkg::FM_LOW_SPEED,   1'b0, 1'b0, fos_pkg::FREQ_8MHZ};
        endcase
    endfunction : cfg_of

    // ==========================================
    // button front end
    fos_btn_if btn ();

    fos_btn_sync u_btn (
        .clk                       (clk),
        .rst                       (rst),
        .clk_en                    (clk_en),
        .button_external_interrupt (button_external_interrupt),
        .btn                       (btn.src)
    );

    // ==========================================
    // registers and bus signals
    fos_pkg::fos_pos_e pos_q;
    fos_pkg::fos_pos_e next_pos_q;
    fos_phase_e        ph_q;
    logic [7:0]        regulator_mode_control_q;
    logic [7:0]        wprot_q;
    logic [1:0]        flash_operating_mode_select_q;
    logic              measure_q;
    logic              cpu_sub_q;
    logic              vdd_ok_q;
    logic [11:0]       vdd_last_q;
    logic [2:0]        irq_stat_q;
    logic [2:0]        irq_en_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [7:0]        aw_addr_q;
    logic [31:0]       w_data_q;
    logic              w_lane0_q;
    logic              wr_fire;
    logic              wr_lane;
    logic              seq_write;
    logic              sw_mode_wr;
    logic              vdd_in_range;
    logic [2:0]        irq_set;
    fos_pkg::fos_cfg_s nxt_cfg;
    fos_pkg::fos_cfg_s cur_cfg;

    localparam logic [2:0] IRQ_RESET_V = fos_pkg::IRQ_RESET;

    assign nxt_cfg      = cfg_of(next_pos_q);
    assign cur_cfg      = cfg_of(pos_q);
    assign wr_fire      = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign wr_lane      = wr_fire & w_lane0_q;
    assign seq_write    = (ph_q == PH_WRITE);
    assign sw_mode_wr   = wr_lane & (aw_addr_q == fos_pkg::REG_FLASH_MODE);
    assign vdd_in_range = (vdd_meas_mv >= fos_pkg::HS_VDD_MIN_MV) && (vdd_meas_mv <= fos_pkg::HS_VDD_MAX_MV);

    // ==========================================
    // axi write channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_lane0_q     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= fos_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_lane0_q    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q[1:0] == 2'h0 && aw_addr_q <= fos_pkg::REG_VDD_RESULT)
                                ? fos_pkg::RESP_OKAY : fos_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================
    // axi read channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= fos_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= fos_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    fos_pkg::REG_REGULATOR_MODE: s_axi_rdata <= {24'h000000, regulator_mode_control_q};
                    fos_pkg::REG_FLASH_WPROT:    s_axi_rdata <= {24'h000000, wprot_q};
                    fos_pkg::REG_FLASH_MODE:     s_axi_rdata <= {30'h0, flash_operating_mode_select_q};
                    fos_pkg::REG_CONTROL:        s_axi_rdata <= {30'h0, cpu_sub_q, measure_q};
                    fos_pkg::REG_STATUS:         s_axi_rdata <= {24'h000000, halt_active, ph_q, vdd_ok_q, pos_q};
                    fos_pkg::REG_IRQ_STATUS:     s_axi_rdata <= {29'h0, irq_stat_q};
                    fos_pkg::REG_IRQ_CLEAR:      s_axi_rdata <= 32'h0000_0000;
                    fos_pkg::REG_IRQ_ENABLE:     s_axi_rdata <= {29'h0, irq_en_q};
                    fos_pkg::REG_VDD_RESULT:     s_axi_rdata <= {20'h00000, vdd_last_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= fos_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================
    // software registers; sequencer write wins over software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regulator_mode_control_q    <= fos_pkg::REGULATOR_RESET;
            wprot_q   <= fos_pkg::WPROT_RESET;
            flash_operating_mode_select_q  <= fos_pkg::FM_LOW_VOLTAGE;
            measure_q <= 1'b0;
            cpu_sub_q <= 1'b0;
            irq_en_q  <= IRQ_RESET_V;
        end else if (clk_en) begin
            if (wr_lane) begin
                unique case (aw_addr_q)
                    fos_pkg::REG_REGULATOR_MODE: regulator_mode_control_q <= w_data_q[7:0] & 8'h40;
                    fos_pkg::REG_FLASH_WPROT:    wprot_q <= {7'h00, w_data_q[0]};
                    fos_pkg::REG_CONTROL: begin
                        measure_q <= w_data_q[fos_pkg::CTRL_MEASURE_BIT];
                        cpu_sub_q <= w_data_q[fos_pkg::CTRL_CPU_SUB_BIT];
                    end
                    fos_pkg::REG_IRQ_ENABLE:     irq_en_q <= w_data_q[2:0];
                    default: ;
                endcase
            end
            if (sw_mode_wr && wprot_q[fos_pkg::WRITE_ENABLE_BIT]) begin
                flash_operating_mode_select_q <= w_data_q[1:0];
            end
            if (ph_q == PH_UNLOCK) begin
                wprot_q[fos_pkg::WRITE_ENABLE_BIT] <= 1'b1;
            end
            if (seq_write && wprot_q[fos_pkg::WRITE_ENABLE_BIT]) begin
                flash_operating_mode_select_q                        <= nxt_cfg.mode;
                regulator_mode_control_q[fos_pkg::LOW_POWER_BIT]  <= nxt_cfg.low_power_reg;
            end
        end
    end

    // ==========================================
    // step sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q         <= PH_IDLE;
            pos_q        <= fos_pkg::POS_LV_HOCO4;
            next_pos_q   <= fos_pkg::POS_LV_HOCO4;
            vdd_meas_req <= 1'b0;
            vdd_ok_q     <= 1'b0;
            vdd_last_q   <= 12'h000;
        end else if (clk_en) begin
            vdd_meas_req <= 1'b0;
            unique case (ph_q)
                PH_IDLE: begin
                    if (btn.press) begin
                        if (pos_q == fos_pkg::POS_LS_N8) begin
                            vdd_meas_req <= 1'b1;
                            ph_q         <= PH_MEAS;
                        end else begin
                            next_pos_q <= seq_next(pos_q, 1'b0);
                            ph_q       <= PH_UNLOCK;
                        end
                    end
                end
                PH_MEAS: begin
                    if (vdd_meas_valid) begin
                        vdd_last_q <= vdd_meas_mv;
                        vdd_ok_q   <= vdd_in_range;
                        next_pos_q <= seq_next(pos_q, vdd_in_range);
                        ph_q       <= PH_UNLOCK;
                    end
                end
                PH_UNLOCK: ph_q <= PH_WRITE;
                PH_WRITE: begin
                    pos_q <= next_pos_q;
                    ph_q  <= PH_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // operating outputs and measurement configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_clock_middle_osc   <= 1'b0;
            osc_freq_mhz            <= fos_pkg::FREQ_4MHZ;
            cpu_clock_source_select <= 1'b0;
            halt_active             <= 1'b0;
            periph_stop             <= 1'b0;
            gpio_out                <= '0;
            gpio_oe                 <= '0;
        end else if (clk_en) begin
            main_clock_middle_osc   <= cur_cfg.middle_osc;
            osc_freq_mhz            <= cur_cfg.freq_mhz;
            cpu_clock_source_select <= cpu_sub_q & ~measure_q;
            periph_stop             <= measure_q;
            gpio_out                <= '0;
            for (int i = 0; i < GPIO_W; i++) begin
                gpio_oe[i] <= measure_q && (i != TOOL_PIN);
            end
            if (!measure_q || btn.press) begin
                halt_active <= 1'b0;
            end else if (ph_q == PH_IDLE) begin
                halt_active <= 1'b1;
            end
        end
    end

    assign flash_operating_mode_select = flash_operating_mode_select_q;
    assign regulator_low_power_select  = regulator_mode_control_q[fos_pkg::LOW_POWER_BIT];

    // ==========================================
    // interrupts: set wins over clear
    always_comb begin
        irq_set                             = 3'h0;
        irq_set[fos_pkg::IRQ_STEP]          = seq_write;
        irq_set[fos_pkg::IRQ_HS_REFUSED]    = (ph_q == PH_MEAS) && vdd_meas_valid && !vdd_in_range;
        irq_set[fos_pkg::IRQ_WRITE_REFUSED] = sw_mode_wr && !wprot_q[fos_pkg::WRITE_ENABLE_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= IRQ_RESET_V;
            irq        <= 1'b0;
        end else if (clk_en) begin
            if (wr_lane && aw_addr_q == fos_pkg::REG_IRQ_CLEAR) begin
                irq_stat_q <= (irq_stat_q & ~w_data_q[2:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wp_refuse: assert property (
        clk_en && sw_mode_wr && !wprot_q[0] && !seq_write |=> $stable(flash_operating_mode_select_q)
    ) else $error("flash mode changed while write protected");
    a_wp_accept: assert property (
        clk_en && sw_mode_wr && wprot_q[0] && !seq_write |=> flash_operating_mode_select_q == $past(w_data_q[1:0])
    ) else $error("enabled flash mode write lost");
    a_regulator_bit: assert property (
        clk_en && wr_lane && aw_addr_q == fos_pkg::REG_REGULATOR_MODE && !seq_write
        |=> regulator_low_power_select == $past(w_data_q[6])
    ) else $error("regulator select does not follow bit 6");
    a_step_once: assert property (
        clk_en && ph_q == PH_IDLE && btn.press && pos_q != fos_pkg::POS_LS_N8
        |=> ph_q == PH_UNLOCK ##1 ph_q == PH_WRITE ##1 ph_q == PH_IDLE
    ) else $error("press did not make one step");
    a_state_order: assert property (
        pos_q != $past(pos_q) |-> pos_q == seq_next($past(pos_q), vdd_ok_q)
    ) else $error("state order broken");
    a_hs_guard: assert property (
        pos_q == fos_pkg::POS_HS16 |-> vdd_ok_q && vdd_last_q >= fos_pkg::HS_VDD_MIN_MV
                                       && vdd_last_q <= fos_pkg::HS_VDD_MAX_MV
    ) else $error("high speed entered outside supply window");
    a_unlock_first: assert property (
        seq_write && !$past(seq_write) |-> wprot_q[0] && $past(ph_q) == PH_UNLOCK
    ) else $error("mode written before write enable set");
    a_halt_wake: assert property (
        halt_active && !$past(halt_active) |-> $past(measure_q) && $past(ph_q) == PH_IDLE
    ) else $error("halt entered outside idle measurement");
    a_pins_low: assert property (
        clk_en && measure_q |=> gpio_out == '0 && !gpio_oe[TOOL_PIN] && periph_stop && !cpu_clock_source_select
    ) else $error("measurement pin or clock setting wrong");

    c_full_step: cover property (ph_q == PH_WRITE && next_pos_q == fos_pkg::POS_LV_HOCO4);
    c_hs_error:  cover property (pos_q == fos_pkg::POS_HS_ERROR);
    c_refused:   cover property (irq_set[fos_pkg::IRQ_WRITE_REFUSED]);
endmodule : fos_sequencer

// >>> tb/fos_btn_model.sv
// button and supply-measurement partner of the sequencer
`timescale 1ns/1ps
module fos_btn_model (
    // clock and stimulus
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [11:0] mv,
    // button pin
    output logic             button_external_interrupt = 1'b0,
    // supply measurement
    input  wire logic        vdd_meas_req,
    output logic             vdd_meas_valid = 1'b0,
    output logic [11:0]      vdd_meas_mv = 12'h000
);
    logic [3:0] hold_q = 4'h0;
    // ==========================================
    // one clean press per go pulse
    always @(posedge clk) begin
        hold_q <= go ? 4'hF : hold_q - 4'(|hold_q);
        button_external_interrupt <= |hold_q;
    end
    // one answer per request, junk in between
    always @(posedge clk) begin
        vdd_meas_valid <= vdd_meas_req;
        vdd_meas_mv <= vdd_meas_req ? mv : ~vdd_meas_mv;
    end
endmodule : fos_btn_model

// >>> tb/tb_flash_operation_state_sequencer.sv
// self-checking bench of the flash operation state sequencer
`timescale 1ns/1ps
module tb_flash_operation_state_sequencer;
    logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, go = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [4:0]  osc_freq_mhz;
    logic [1:0]  s_axi_bresp, s_axi_rresp, flash_operating_mode_select;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        button_external_interrupt, vdd_meas_req, vdd_meas_valid, regulator_low_power_select;
    logic        main_clock_middle_osc, cpu_clock_source_select, halt_active, periph_stop;
    logic [11:0] vdd_meas_mv, mv = 12'h960;
    logic [15:0] gpio_out, gpio_oe;
    logic [33:0] exq[$];
    logic [33:0] cfg[9] = '{34'h004, 34'h024, 34'h0E4, 34'h088, 34'h110, 34'h088, 34'h1A1, 34'h088, 34'h004};
    int          fails = 0, total_checks = 0;
    wire  [33:0] cfg_w = 34'({flash_operating_mode_select, regulator_low_power_select, main_clock_middle_osc,
                              osc_freq_mhz});
    fos_sequencer dut (.clk, .rst, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .button_external_interrupt, .vdd_meas_req, .vdd_meas_valid, .vdd_meas_mv, .flash_operating_mode_select,
        .regulator_low_power_select, .main_clock_middle_osc, .osc_freq_mhz, .cpu_clock_source_select,
        .halt_active, .periph_stop, .gpio_out, .gpio_oe, .irq);
    fos_btn_model partner (.clk, .go, .mv, .button_external_interrupt, .vdd_meas_req, .vdd_meas_valid,
        .vdd_meas_mv);
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        chk(34'(s_axi_bresp), 34'(fos_pkg::RESP_OKAY));
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        exq.push_back(e);
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic press();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (40) @(posedge clk);
    endtask : press
    always #5 clk = ~clk;
    // read results against the oldest note
    always @(posedge clk) if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exq.pop_front());
    initial begin #100us; fails++; finish_test(); end
    initial begin
        void'($urandom(32'h8702));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk(cfg_w, cfg[0]);
        rd(8'h00, 34'h0);
        rd(8'h04, 34'h1);
        rd(8'h24, 34'h200000000);
        wr(8'h00, 32'h40);
        rd(8'h00, 34'h40);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h2);
        rd(8'h08, 34'h0);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h2);
        rd(8'h08, 34'h2);
        wr(8'h08, 32'h0);
        wr(8'h1C, 32'h4);
        repeat (3) @(posedge clk);
        chk(34'(irq), 34'h1);
        wr(8'h1C, 32'h0);
        repeat (3) @(posedge clk);
        chk(34'(irq), 34'h0);
        wr(8'h18, 32'h7);
        rd(8'h14, 34'h0);
        for (int lap = 0; lap < 2; lap++) begin
            wr(8'h0C, {30'h0, lap[0], lap[0]});
            mv <= lap[0] ? 12'h95F : 12'h960 + 12'($urandom % 32'h4B1);
            for (int i = 1; i < 9; i++) begin
                press();
                chk(cfg_w, (lap == 1 && i == 4) ? 34'h088 : cfg[i]);
            end
        end
        clk_en <= 1'b0;
        press();
        clk_en <= 1'b1;
        chk(cfg_w, cfg[0]);
        chk(34'({halt_active, periph_stop, cpu_clock_source_select}), 34'h6);
        chk(34'({gpio_out, gpio_oe}), 34'hFFFE);
        rd(8'h14, 34'h3);
        finish_test();
    end
endmodule : tb_flash_operation_state_sequencer
